// [rtl/lsd_pkg.sv]
// How it works
// - sixteen 6-bit current trims, value over 63
// - trim packet 96 bits, top channel MSB first
// - mode high selects 96-bit shift register
// - trim latch transparent while strobe high
// - trims act at strobe rise, blanking ignored
// - sixteen 12-bit brightness levels, value over 4095
// - brightness packet 192 bits, MSB first
// - mode low, strobe rise loads all levels
// - after level load, status replaces shift register
// - status: open bits 0-15, temp 16, trims 24-119
// - status MSB out at strobe fall, then shifts
// - on and low for 1 us flags open
// - blanking fall starts cycle, first pulse on
// - later pulses count, count above level switches off
// - counter stops at FFFh, all outputs off
// - blanking high clears counter at once
// - blanking high disables outputs, clears counter
// - open flags captured when strobe falls
package lsd_pkg;
  localparam int NCH = 16;
  localparam int TRIM_W = 6;
  localparam int LVL_W = 12;
  localparam int DC_LEN = 96;
  localparam int GS_LEN = 192;
  localparam int ST_OPEN_LSB = 0;
  localparam int ST_OT_BIT = 16;
  localparam int ST_TRIM_LSB = 24;
  localparam int SYS_CLK_MHZ = 100;
  localparam int OPEN_DETECT_NS = 1000;
  // longest time: round down, never below one cycle
  localparam int OPEN_DETECT_RAW = OPEN_DETECT_NS * SYS_CLK_MHZ / 1000;
  localparam int OPEN_DETECT_CYC = (OPEN_DETECT_RAW < 1) ? 1 : OPEN_DETECT_RAW;
  localparam logic [LVL_W-1:0] CNT_MAX = 12'hfff;
  localparam logic [LVL_W-1:0] CNT_RST = 12'h000;
  localparam logic [DC_LEN-1:0] TRIM_RST = '0;
  localparam logic [GS_LEN-1:0] SR_RST = '0;
  typedef enum logic [1:0] {
    LS_IDLE = 2'h0,
    LS_HIGH = 2'h1,
    LS_STATUS = 2'h3
  } lsd_latch_t;
endpackage

// [rtl/lsd_chan_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface lsd_chan_if;
  logic ce;
  logic blank;
  logic [lsd_pkg::LVL_W-1:0] count;
  logic [lsd_pkg::NCH-1:0][lsd_pkg::LVL_W-1:0] level;
  logic [lsd_pkg::NCH-1:0] low_v;
  logic [lsd_pkg::NCH-1:0] on;
  logic [lsd_pkg::NCH-1:0] open;
  modport core(output ce, blank, count, level, low_v, input on, open);
  modport chan(input ce, blank, count, level, low_v, output on, open);
endinterface
`default_nettype wire

// [rtl/lsd_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module lsd_sync #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst_n, // destination reset
  input wire logic en, // clock enable
  input wire logic [W-1:0] d, // foreign level
  output logic [W-1:0] q // synchronised level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (en) begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule
`default_nettype wire

// [rtl/lsd_chan.sv]
`timescale 1ns/100ps
`default_nettype none
module lsd_chan #(
  parameter int IDX = 0,
  parameter int DETECT_CYC = lsd_pkg::OPEN_DETECT_CYC
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset
  lsd_chan_if.chan bus // shared channel signals
);
  localparam int CW = $clog2(DETECT_CYC + 1);
  initial begin
    if (IDX < 0 || IDX >= lsd_pkg::NCH || DETECT_CYC < 1) begin
      $error("lsd_chan: bad parameters");
    end
  end

  logic on_q;
  logic [CW-1:0] dly_q;
  wire [lsd_pkg::LVL_W-1:0] lvl = bus.level[IDX];
  wire cnt_run = (bus.count != lsd_pkg::CNT_RST) && (bus.count != lsd_pkg::CNT_MAX);
  wire on_d = !bus.blank && cnt_run && (bus.count <= lvl);
  wire dly_full = (dly_q == CW'(DETECT_CYC));
  wire suspect = on_q && bus.low_v[IDX];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_q <= 1'b0;
      dly_q <= '0;
    end else if (bus.ce) begin
      on_q <= on_d;
      // flag only after a full delay of low voltage while sinking
      if (!suspect) begin
        dly_q <= '0;
      end else if (!dly_full) begin
        dly_q <= dly_q + 1'b1;
      end
    end
  end

  assign bus.on[IDX] = on_q;
  assign bus.open[IDX] = dly_full;
endmodule
`default_nettype wire

// [rtl/lsd_top.sv]
`timescale 1ns/100ps
`default_nettype none
module lsd_top #(
  parameter int NCH = lsd_pkg::NCH,
  parameter int TRIM_W = lsd_pkg::TRIM_W,
  parameter int LVL_W = lsd_pkg::LVL_W,
  parameter int DETECT_CYC = lsd_pkg::OPEN_DETECT_CYC
) (
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, low
  input wire logic ce, // clock enable
  input wire logic shift_clk, // serial shift clock
  input wire logic serial_data_input, // serial data in
  input wire logic latch_strobe, // latch strobe pin
  input wire logic mode_dc, // high: trim mode
  input wire logic blank, // blanking pin
  input wire logic pwm_count_clock, // pwm count clock pin
  input wire logic over_temp_flag, // thermal sensor level
  input wire logic [NCH-1:0] low_voltage, // per channel below 0.3 V
  output logic [NCH-1:0] sink_output, // channel sink enables
  output logic [NCH*TRIM_W-1:0] current_trim, // per channel trims
  output logic serial_data_output, // serial data out
  input wire logic error_out_n_i, // error wire level
  output logic error_out_n_o, // error drive value
  output logic error_out_n_oe // error pull-down enable
);

  // ---------------------------------------------------------------
  // checks and constants
  // ---------------------------------------------------------------
  localparam int DC_LEN = NCH * TRIM_W;
  localparam int GS_LEN = NCH * LVL_W;
  localparam int SYNC_W = 5 + NCH;

  initial begin
    if (NCH != lsd_pkg::NCH || TRIM_W != lsd_pkg::TRIM_W ||
        LVL_W != lsd_pkg::LVL_W || DETECT_CYC < 1) begin
      $error("lsd_top: unsupported parameters");
    end
  end

  // ---------------------------------------------------------------
  // reset release, system domain
  // ---------------------------------------------------------------
  logic [1:0] rst_ff_q;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_ff_q <= 2'h0;
    end else begin
      rst_ff_q <= {rst_ff_q[0], 1'b1};
    end
  end

  assign rst_n = rst_ff_q[1];

  // ---------------------------------------------------------------
  // pin synchronisers, system domain
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  logic latch_s;
  logic mode_s;
  logic blank_s;
  logic pcc_s;
  logic ot_s;
  logic [NCH-1:0] low_s;

  lsd_sync #(.W(SYNC_W)) u_sync_sys (
    .clk(sys_clk),
    .rst_n(rst_n),
    .en(ce),
    .d({latch_strobe, mode_dc, blank, pwm_count_clock, over_temp_flag, low_voltage}),
    .q(pins_s)
  );

  assign latch_s = pins_s[NCH+4];
  assign mode_s = pins_s[NCH+3];
  assign blank_s = pins_s[NCH+2];
  assign pcc_s = pins_s[NCH+1];
  assign ot_s = pins_s[NCH];
  assign low_s = pins_s[NCH-1:0];

  // ---------------------------------------------------------------
  // link domain: reset release and crossings
  // ---------------------------------------------------------------
  logic [1:0] lrst_ff_q;
  logic lrst_n;
  logic req_q;
  logic ack_q;
  logic mode_l;
  logic req_l;
  logic ce_l;

  always_ff @(posedge shift_clk or negedge nrst) begin
    if (!nrst) begin
      lrst_ff_q <= 2'h0;
    end else begin
      lrst_ff_q <= {lrst_ff_q[0], 1'b1};
    end
  end

  assign lrst_n = lrst_ff_q[1];

  // the link clock stands still outside transfers, so the status
  // request is seen only after two shift clock edges have passed
  lsd_sync #(.W(3)) u_sync_lnk (
    .clk(shift_clk),
    .rst_n(lrst_n),
    .en(1'b1),
    .d({mode_dc, req_q, ce}),
    .q({mode_l, req_l, ce_l})
  );

  // ---------------------------------------------------------------
  // input shift register, link domain
  // ---------------------------------------------------------------
  logic [GS_LEN-1:0] sr_q;
  logic [GS_LEN-1:0] stat_q;
  logic [GS_LEN-1:0] sr_d;
  logic [GS_LEN-1:0] sr_gs;
  logic [GS_LEN-1:0] sr_dc;
  logic [GS_LEN-1:0] sr_ld;
  logic sh_load;
  logic sr_top;

  assign sh_load = (req_l != ack_q);
  assign sr_gs = {sr_q[GS_LEN-2:0], serial_data_input};
  // trim mode: only the low 96 bits shift, the rest holds
  assign sr_dc = {sr_q[GS_LEN-1:DC_LEN], sr_q[DC_LEN-2:0], serial_data_input};
  // status MSB has already gone out, so load shifted by one
  assign sr_ld = {stat_q[GS_LEN-2:0], serial_data_input};
  assign sr_d = sh_load ? sr_ld : (mode_l ? sr_dc : sr_gs);
  assign sr_top = mode_l ? sr_q[DC_LEN-1] : sr_q[GS_LEN-1];

  always_ff @(posedge shift_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      sr_q <= lsd_pkg::SR_RST;
      ack_q <= 1'b0;
    end else if (ce_l) begin
      sr_q <= sr_d;
      ack_q <= req_l;
    end
  end

  // ---------------------------------------------------------------
  // latch strobe sequencing, system domain
  // ---------------------------------------------------------------
  lsd_pkg::lsd_latch_t state_q;
  lsd_pkg::lsd_latch_t state_d;
  logic in_high;
  logic rise;
  logic fall;
  logic gs_load;
  logic trim_open;
  logic was_gs_q;
  logic ack_s;
  logic acked;

  lsd_sync #(.W(1)) u_sync_ack (
    .clk(sys_clk),
    .rst_n(rst_n),
    .en(ce),
    .d(ack_q),
    .q(ack_s)
  );

  assign in_high = (state_q == lsd_pkg::LS_HIGH);
  assign rise = latch_s && !in_high;
  assign fall = in_high && !latch_s;
  assign gs_load = rise && !mode_s;
  assign trim_open = latch_s && mode_s;
  assign acked = (ack_s == req_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      lsd_pkg::LS_IDLE: begin
        if (latch_s) begin
          state_d = lsd_pkg::LS_HIGH;
        end
      end
      lsd_pkg::LS_HIGH: begin
        if (!latch_s) begin
          state_d = was_gs_q ? lsd_pkg::LS_STATUS : lsd_pkg::LS_IDLE;
        end
      end
      lsd_pkg::LS_STATUS: begin
        if (latch_s) begin
          state_d = lsd_pkg::LS_HIGH;
        end else if (acked) begin
          state_d = lsd_pkg::LS_IDLE;
        end
      end
      default: begin
        state_d = lsd_pkg::LS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= lsd_pkg::LS_IDLE;
      was_gs_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      if (rise) begin
        was_gs_q <= !mode_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // trim and brightness registers
  // ---------------------------------------------------------------
  logic [DC_LEN-1:0] trim_q;
  logic [GS_LEN-1:0] level_q;

  // shift register words are still while the strobe is high,
  // so sampling them here after the strobe sync is safe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_q <= lsd_pkg::TRIM_RST;
    end else if (ce && trim_open) begin
      trim_q <= sr_q[DC_LEN-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= lsd_pkg::SR_RST;
    end else if (ce && gs_load) begin
      level_q <= sr_q;
    end
  end

  assign current_trim = trim_q;

  // ---------------------------------------------------------------
  // status packet
  // ---------------------------------------------------------------
  logic [GS_LEN-1:0] stat_d;
  logic [NCH-1:0] open_all;

  always_comb begin
    stat_d = '0;
    stat_d[lsd_pkg::ST_OPEN_LSB +: NCH] = open_all;
    stat_d[lsd_pkg::ST_OT_BIT] = ot_s;
    stat_d[lsd_pkg::ST_TRIM_LSB +: DC_LEN] = trim_q;
  end

  // request toggles in the same cycle the snapshot is written;
  // the shift register loads the snapshot only after syncing the toggle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= lsd_pkg::SR_RST;
      req_q <= 1'b0;
    end else if (ce && fall) begin
      stat_q <= stat_d;
      if (was_gs_q) begin
        req_q <= !req_q;
      end
    end
  end

  // status MSB stands from snapshot until the load edge itself; waiting
  // for the synced acknowledge would hold it past several shift edges
  assign serial_data_output = (req_q != ack_q) ? stat_q[GS_LEN-1] : sr_top;

  // ---------------------------------------------------------------
  // grayscale counter
  // ---------------------------------------------------------------
  logic pcc_d1_q;
  logic [LVL_W-1:0] cnt_q;
  logic pcc_rise;
  logic cnt_stop;

  assign pcc_rise = pcc_s && !pcc_d1_q;
  assign cnt_stop = (cnt_q == lsd_pkg::CNT_MAX);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcc_d1_q <= 1'b0;
      cnt_q <= lsd_pkg::CNT_RST;
    end else if (ce) begin
      pcc_d1_q <= pcc_s;
      if (blank_s) begin
        cnt_q <= lsd_pkg::CNT_RST;
      end else if (pcc_rise && !cnt_stop) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  lsd_chan_if chans ();

  assign chans.ce = ce;
  assign chans.blank = blank_s;
  assign chans.count = cnt_q;
  assign chans.level = level_q;
  assign chans.low_v = low_s;
  assign open_all = chans.open;

  for (genvar i = 0; i < NCH; i++) begin : g_chan
    lsd_chan #(
      .IDX(i),
      .DETECT_CYC(DETECT_CYC)
    ) u_chan (
      .clk(sys_clk),
      .rst_n(rst_n),
      .bus(chans.chan)
    );
  end

  assign sink_output = chans.on;

  // ---------------------------------------------------------------
  // error pin
  // ---------------------------------------------------------------
  logic err_q;
  logic err_d;

  // open flags are masked under blanking so software can tell
  // thermal trouble apart; the wire level itself is not needed
  assign err_d = ot_s || ((|open_all) && !blank_s);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else if (ce) begin
      err_q <= err_d;
    end
  end

  assign error_out_n_o = 1'b0;
  assign error_out_n_oe = err_q;

endmodule
`default_nettype wire

// [test/lsd_top_props.sv]
`timescale 1ns/100ps
`default_nettype none
module lsd_top_props #(
  parameter int NCH = 16,
  parameter int TRIM_W = 6,
  parameter int DETECT_CYC = 100
) (
  input wire logic sys_clk, // system clock
  input wire logic nrst, // reset, low
  input wire logic shift_clk, // link clock
  input wire logic serial_data_input, // link data in
  input wire logic latch_strobe, // strobe
  input wire logic mode_dc, // trim mode
  input wire logic blank, // blanking
  input wire logic over_temp_flag, // thermal level
  input wire logic [NCH-1:0] low_voltage, // low outputs
  input wire logic [NCH-1:0] sink_output, // sinks
  input wire logic [NCH*TRIM_W-1:0] current_trim, // trims
  input wire logic serial_data_output, // link data out
  input wire logic error_out_n_o, // error value
  input wire logic error_out_n_oe // error enable
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [5:0] st_q;
  logic [7:0] low_q;
  logic [7:0] run_q;
  wire lit = (sink_output & low_voltage) != '0;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
      low_q <= 8'h00;
    end else begin
      st_q <= {st_q[4:0], latch_strobe};
      // blanking masks the open flag, so low time only counts unblanked
      if (!lit || blank) low_q <= 8'h00;
      else if (low_q != 8'hff) low_q <= low_q + 8'h01;
    end
  end
  // edges since trim mode began; saturates so long runs stay valid
  always_ff @(posedge shift_clk or negedge nrst) begin
    if (!nrst) run_q <= 8'h00;
    else if (!mode_dc) run_q <= 8'h00;
    else if (run_q != 8'hff) run_q <= run_q + 8'h01;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_blank_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    blank [*5] |-> sink_output == '0) else $error("sinks on while blanked");
  a_pwm_start: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(blank) |-> (sink_output == '0) [*3]) else $error("sink on before count");
  a_trim_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    $changed(current_trim) |-> st_q != '0 && mode_dc) else $error("trim moved");
  a_dc_shift: assert property (@(posedge shift_clk) disable iff (!nrst)
    run_q >= 8'h70 |-> serial_data_output == $past(serial_data_input, 96))
    else $error("trim path length wrong");
  a_open_err: assert property (@(posedge sys_clk) disable iff (!nrst)
    low_q >= DETECT_CYC + 5 |-> error_out_n_oe) else $error("open not flagged");
  a_temp_err: assert property (@(posedge sys_clk) disable iff (!nrst)
    over_temp_flag [*5] |-> error_out_n_oe) else $error("hot not flagged");
  a_err_mask: assert property (@(posedge sys_clk) disable iff (!nrst)
    (blank && !over_temp_flag) [*5] |-> !error_out_n_oe) else $error("error not masked");
  a_err_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
    error_out_n_oe |-> !error_out_n_o) else $error("error wire not pulled low");
  cover property (@(posedge sys_clk) $fell(latch_strobe) && !mode_dc);
  cover property (@(posedge sys_clk) $rose(error_out_n_oe));
  cover property (@(posedge sys_clk) sink_output[15]);
endmodule
bind lsd_top lsd_top_props #(.NCH(NCH), .TRIM_W(TRIM_W), .DETECT_CYC(DETECT_CYC))
  i_lsd_top_props (.sys_clk(sys_clk), .nrst(nrst), .shift_clk(shift_clk),
  .serial_data_input(serial_data_input), .latch_strobe(latch_strobe), .mode_dc(mode_dc),
  .blank(blank), .over_temp_flag(over_temp_flag), .low_voltage(low_voltage),
  .sink_output(sink_output), .current_trim(current_trim),
  .serial_data_output(serial_data_output), .error_out_n_o(error_out_n_o),
  .error_out_n_oe(error_out_n_oe));
`default_nettype wire

// [test/lsd_host.sv]
`timescale 1ns/100ps
`default_nettype none
module lsd_host (
  input wire logic lclk, // free link clock
  input wire logic sdo, // device serial out
  output var logic shift_clk, // gated shift clock
  output var logic sdi, // serial data
  output var logic strobe, // latch strobe
  output var logic [191:0] rx // captured status
);
  initial begin
    shift_clk = 1'b0;
    sdi = 1'b0;
    strobe = 1'b0;
    rx = '0;
  end
  // one rise per bit; sdo read at the fall, well clear of its update
  task automatic bit_out(input logic b, input logic cap);
    @(negedge lclk) shift_clk = 1'b0;
    if (cap) rx = {rx[190:0], sdo};
    sdi = b;
    @(posedge lclk) shift_clk = 1'b1;
  endtask
  task automatic frame(input int n, input logic [191:0] d, input logic dc, input logic lat);
    // status MSB was taken after the previous strobe, so skip that slot
    for (int i = n - 1; i >= 0; i--) bit_out(d[i], i < n - 1);
    @(negedge lclk) shift_clk = 1'b0;
    sdi = ~d[0];
    if (lat) begin
      #20 strobe = 1'b1;
      #60 strobe = 1'b0;
      #60;
      if (!dc) begin
        rx = {rx[190:0], sdo};
        bit_out(1'b0, 1'b0);
        bit_out(1'b1, 1'b0);
        @(negedge lclk) shift_clk = 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// [test/led_sink_dimming_shift_pwm_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module led_sink_dimming_shift_pwm_bench;
  localparam logic [95:0] TP = 96'h0123_4567_89ab_cdef_fedc_ba98;
  localparam logic [191:0] LV = {12'hfff, 144'h0, 12'h001, 12'h000, 12'h003};
  logic sys_clk = 1'b0;
  logic lclk = 1'b0;
  logic nrst = 1'b1;
  logic mode_dc = 1'b0;
  logic blank = 1'b1;
  logic pcc = 1'b0;
  logic hot = 1'b0;
  logic [15:0] low = 16'h0;
  logic [15:0] sink;
  logic [95:0] trim;
  logic shift_clk;
  logic sdi;
  logic sdo;
  logic strobe;
  logic err_o;
  logic err_oe;
  logic [191:0] rx;
  wire err_i = err_oe ? err_o : 1'b1;
  int errors = 0;
  int cmp_count = 0;
  always #5 sys_clk = ~sys_clk;
  // link clock, phase unrelated to sys_clk
  initial begin
    #1.3;
    forever #3 lclk = ~lclk;
  end
  lsd_top #(.DETECT_CYC(4)) i_lsd_top (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1),
    .shift_clk(shift_clk), .serial_data_input(sdi), .latch_strobe(strobe),
    .mode_dc(mode_dc), .blank(blank), .pwm_count_clock(pcc), .over_temp_flag(hot),
    .low_voltage(low), .sink_output(sink), .current_trim(trim), .serial_data_output(sdo),
    .error_out_n_i(err_i), .error_out_n_o(err_o), .error_out_n_oe(err_oe));
  lsd_host i_lsd_host (.lclk(lclk), .sdo(sdo), .shift_clk(shift_clk), .sdi(sdi),
    .strobe(strobe), .rx(rx));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [191:0] e, input logic [191:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // each level held 3 cycles so the synchroniser sees every edge
  task automatic pulse(input int n);
    repeat (n) begin
      cyc(1);
      pcc = 1'b1;
      cyc(3);
      pcc = 1'b0;
      cyc(2);
    end
    cyc(4);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    // a real falling edge, so the idle link clock domain resets too
    #2;
    nrst = 1'b0;
    cyc(10);
    nrst = 1'b1;
    i_lsd_host.frame(2, '0, 1'b0, 1'b0);
    cyc(4);
    chk("reset sinks", 16'h0, sink);
    chk("reset trim", 96'h0, trim);
    i_lsd_host.frame(192, '0, 1'b0, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_trim();
    cyc(1);
    mode_dc = 1'b1;
    blank = 1'b0;
    i_lsd_host.frame(96, {96'h0, TP}, 1'b1, 1'b1);
    chk("trim", TP, trim);
    i_lsd_host.frame(96, {96'h0, ~TP}, 1'b1, 1'b0);
    chk("trim hold", TP, trim);
    cyc(1);
    blank = 1'b1;
    $display("test trim done");
  endtask
  task automatic t_status();
    cyc(1);
    mode_dc = 1'b0;
    hot = 1'b1;
    i_lsd_host.frame(192, LV, 1'b0, 1'b1);
    chk("error wire", 1'b0, err_i);
    i_lsd_host.frame(192, LV, 1'b0, 1'b0);
    chk("status", {72'h0, TP, 8'h01, 16'h0}, rx);
    cyc(1);
    hot = 1'b0;
    $display("test status done");
  endtask
  task automatic t_pwm();
    cyc(1);
    blank = 1'b0;
    cyc(4);
    chk("pwm idle", 16'h0, sink);
    pulse(1);
    chk("pwm 1", 16'h8005, sink);
    pulse(1);
    chk("pwm 2", 16'h8001, sink);
    pulse(2);
    chk("pwm 4", 16'h8000, sink);
    pulse(4090);
    chk("pwm 4094", 16'h8000, sink);
    pulse(3);
    chk("pwm max", 16'h0, sink);
    blank = 1'b1;
    cyc(6);
    chk("blanked", 16'h0, sink);
    blank = 1'b0;
    pulse(1);
    chk("restart", 16'h8005, sink);
    $display("test pwm done");
  endtask
  task automatic t_open();
    int k;
    k = 0;
    low = 16'h0001;
    while (err_oe !== 1'b1 && k < 12) begin
      cyc(1);
      k++;
    end
    chk("open error", 1'b1, err_oe);
    i_lsd_host.frame(192, LV, 1'b0, 1'b1);
    i_lsd_host.frame(192, LV, 1'b0, 1'b0);
    chk("open status", {72'h0, TP, 8'h00, 16'h0001}, rx);
    cyc(1);
    blank = 1'b1;
    cyc(6);
    chk("error masked", 1'b0, err_oe);
    low = 16'h0;
    $display("test open done");
  endtask
  initial begin
    t_reset();
    t_trim();
    t_status();
    t_pwm();
    t_open();
    end_sim();
  end
  initial begin
    #600us;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
